// [mioc_addr_dec.v]
`include "mioc_cfg_map.vh"
`default_nettype none
// general address decoder, combinational
module mioc_addr_dec (
	// programmed window
	input  wire [6:0]  i_match_bits,
	input  wire [1:0]  i_mode,
	// host address and qualifier
	input  wire [10:0] i_addr,
	input  wire        i_chip_select_qualifier_n,
	// select
	output reg         o_hit
);
	wire upper_ok; // bits 10:4 agree
	assign upper_ok = (i_addr[10:4] == i_match_bits) && !i_chip_select_qualifier_n;
	// low nibble match per mode
	always @* begin
		case (i_mode)
			`MIOC_DEC_OFF:     o_hit = 1'b0;
			`MIOC_DEC_ONE:     o_hit = upper_ok && (i_addr[3:0] == 4'h0);
			`MIOC_DEC_EIGHT:   o_hit = upper_ok && !i_addr[3];
			`MIOC_DEC_SIXTEEN: o_hit = upper_ok;
			default:           o_hit = 1'b0;
		endcase
	end
endmodule // mioc_addr_dec
`default_nettype wire

// [mioc_cfg_map.vh]
`ifndef MIOC_CFG_MAP_VH
`define MIOC_CFG_MAP_VH
// register indices
`define MIOC_IDX_DRV_TYPES   8'h06
`define MIOC_IDX_PWR_BOOT    8'h07
`define MIOC_IDX_DEC_LO      8'h08
`define MIOC_IDX_DEC_HI      8'h09
`define MIOC_IDX_ECP_THR     8'h0a
`define MIOC_IDX_RATE_TBL    8'h0b
`define MIOC_IDX_SER_MODE    8'h0c
// reset values
`define MIOC_RST_DRV_TYPES   8'hff
`define MIOC_RST_ZERO        8'h00
// writable bit masks, reserved bits clear
`define MIOC_MASK_ALL        8'hff
`define MIOC_MASK_PWR_BOOT   8'hf3
`define MIOC_MASK_DEC_LO     8'h0f
`define MIOC_MASK_DEC_HI     8'hc7
`define MIOC_MASK_ECP_THR    8'h0f
// decoder modes
`define MIOC_DEC_OFF         2'h0
`define MIOC_DEC_ONE         2'h1
`define MIOC_DEC_EIGHT       2'h2
`define MIOC_DEC_SIXTEEN     2'h3
// serial mode codes
`define MIOC_SER_STD         3'h0
`define MIOC_SER_SIR         3'h1
`define MIOC_SER_ASK         3'h2
`endif

// [mioc_cfg_monitor.sv]
`default_nettype none
// port-level checks; write effects are judged one edge after the strobe
module mioc_cfg_monitor (
	input wire logic       i_core_clk, i_rst, i_cfg_mode, i_wr_stb, i_rd_stb, o_rd_hit,
	input wire logic [7:0] i_config_select_index, i_wr_data, o_rd_data,
	input wire logic       i_uart2_rx_pin, o_uart2_rx, i_uart2_tx, o_uart2_tx_pin,
	input wire logic       i_chip_select_qualifier_n, o_general_address_decoder_output,
	input wire logic [3:0] o_fifo_threshold_bit,
	input wire logic [1:0] o_boot_drive,
	input wire logic       o_apd_floppy, o_apd_uart1, o_apd_uart2, o_apd_parallel,
	input wire logic       o_uart2_half_duplex, o_uart1_high_speed, o_uart2_high_speed
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [7:0] wd_q; // write data one edge late
	always_ff @(posedge i_core_clk) wd_q <= i_wr_data;
	// a taken write or read at one index
	sequence s_wr(logic [7:0] x);
		i_wr_stb && i_cfg_mode && i_config_select_index == x;
	endsequence
	sequence s_rd(logic [7:0] x);
		i_rd_stb && i_cfg_mode && i_config_select_index == x;
	endsequence
	a_hit_only_mapped: assert property (
		o_rd_hit == (i_rd_stb && i_cfg_mode && i_config_select_index inside {[8'h06:8'h0c]}))
		else $error("read hit wrong");
	a_miss_reads_zero: assert property (!o_rd_hit |=> o_rd_data == 8'h00)
		else $error("refused read not zero");
	a_pwr_reserved: assert property (s_rd(8'h07) |=> o_rd_data[3:2] == 2'h0)
		else $error("reserved bits not zero");
	a_thr_upper_zero: assert property (s_rd(8'h0a) |=> o_rd_data[7:4] == 4'h0)
		else $error("threshold upper nibble set");
	a_thr_update: assert property (s_wr(8'h0a) |=> o_fifo_threshold_bit == wd_q[3:0])
		else $error("threshold not written");
	a_pwr_boot_update: assert property (s_wr(8'h07) |=>
		{o_apd_floppy, o_apd_uart1, o_apd_uart2, o_apd_parallel, o_boot_drive}
		== {wd_q[7:4], wd_q[1:0]}) else $error("power-down or boot wrong");
	a_serial_polarity: assert property (s_wr(8'h0c) |=>
		o_uart2_rx == (i_uart2_rx_pin ^ wd_q[0]) && o_uart2_tx_pin == (i_uart2_tx ^ wd_q[1]))
		else $error("serial polarity wrong");
	a_duplex_speed: assert property (s_wr(8'h0c) |=>
		{o_uart2_high_speed, o_uart1_high_speed, o_uart2_half_duplex} == {wd_q[7:6], wd_q[2]})
		else $error("duplex or speed wrong");
	a_dec_qualified: assert property (
		o_general_address_decoder_output |-> !i_chip_select_qualifier_n)
		else $error("decode without qualifier");
endmodule // mioc_cfg_monitor
bind mioc_cfg_regs mioc_cfg_monitor mon_u (.*);
`default_nettype wire

// [mioc_cfg_regs.v]
// Functional notes
// - access only in config mode, matching index
// - index 06 drive types, resets ffh
// - boot drive bits 1:0, 0=A, 1=B
// - bits 7:4 enable per-function auto power-down
// - power-down enables clear on reset
// - index 08 gives decoder address 7:4
// - index 09 bits 2:0 give address 10:8
// - index 09 bits 7:6 select decoder mode
// - decoder output needs qualifier low
// - index 0a holds four-bit ECP threshold
// - index 0a upper nibble reads zero
// - index 0b two bits rate table per drive
// - index 0c bit0 inverts second receive
// - index 0c bit1 inverts second transmit
// - index 0c bit2 selects half duplex
// - index 0c bits 5:3 second UART mode
// - index 0c bits 6,7 high-speed enables
// - index 0c clears on reset
`include "mioc_cfg_map.vh"
`default_nettype none
module mioc_cfg_regs (
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// configuration access
	input  wire        i_cfg_mode,
	input  wire [7:0]  i_config_select_index,
	input  wire        i_wr_stb,
	input  wire        i_rd_stb,
	input  wire [7:0]  i_wr_data,
	output reg  [7:0]  o_rd_data,
	output wire        o_rd_hit,
	// decoder pins
	input  wire [10:0] i_addr,
	input  wire        i_chip_select_qualifier_n,
	output wire        o_general_address_decoder_output,
	// second uart serial path
	input  wire        i_uart2_rx_pin,
	output wire        o_uart2_rx,
	input  wire        i_uart2_tx,
	output wire        o_uart2_tx_pin,
	// settings to engines
	output wire [7:0]  o_floppy_drive_types,
	output wire [1:0]  o_boot_drive,
	output wire        o_apd_parallel,
	output wire        o_apd_uart2,
	output wire        o_apd_uart1,
	output wire        o_apd_floppy,
	output wire [3:0]  o_fifo_threshold_bit,
	output wire [7:0]  o_rate_table_select_bit,
	output wire        o_uart2_half_duplex,
	output wire        o_uart2_serial_infrared_mode,
	output wire        o_uart2_amplitude_keyed_infrared,
	output wire        o_uart2_mode_reserved,
	output wire        o_uart1_high_speed,
	output wire        o_uart2_high_speed
);
	localparam NREG = 7; // slots 06h..0ch
	// register store, indexed from slot 06h
	reg  [7:0] regs_q [0:NREG-1];
	wire [7:0] wmask  [0:NREG-1];
	wire       in_range;          // index inside this bank
	wire [2:0] slot;              // index minus base
	wire [7:0] idx_off;           // index minus base, full width

	assign idx_off  = i_config_select_index - `MIOC_IDX_DRV_TYPES;
	assign slot     = idx_off[2:0];
	// access only while config mode and index selects us
	assign in_range = i_cfg_mode && (i_config_select_index >= `MIOC_IDX_DRV_TYPES)
		&& (i_config_select_index <= `MIOC_IDX_SER_MODE);
	assign o_rd_hit = in_range && i_rd_stb;

	// per-slot masks; reserved bits never stored, so they read zero
	assign wmask[0]  = `MIOC_MASK_ALL;
	assign wmask[1]  = `MIOC_MASK_PWR_BOOT;
	assign wmask[2]  = `MIOC_MASK_DEC_LO;
	assign wmask[3]  = `MIOC_MASK_DEC_HI;
	assign wmask[4]  = `MIOC_MASK_ECP_THR;
	assign wmask[5]  = `MIOC_MASK_ALL;
	assign wmask[6]  = `MIOC_MASK_ALL;
	// one flop row per slot; constant reset values only
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			always @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					// drive types ffh, all others zero
					regs_q[g] <= (g == 0) ? `MIOC_RST_DRV_TYPES : `MIOC_RST_ZERO;
				end else if (in_range && i_wr_stb && (slot == g)) begin
					regs_q[g] <= i_wr_data & wmask[g];
				end
			end
		end
	endgenerate

	// read data registered; zero when not addressed
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= `MIOC_RST_ZERO;
		end else if (in_range && i_rd_stb) begin
			o_rd_data <= regs_q[slot];
		end else begin
			o_rd_data <= `MIOC_RST_ZERO;
		end
	end

	// field breakout
	assign o_floppy_drive_types    = regs_q[0];
	assign o_boot_drive            = regs_q[1][1:0];
	assign o_apd_parallel          = regs_q[1][4];
	assign o_apd_uart2             = regs_q[1][5];
	assign o_apd_uart1             = regs_q[1][6];
	assign o_apd_floppy            = regs_q[1][7];
	assign o_fifo_threshold_bit    = regs_q[4][3:0];
	assign o_rate_table_select_bit = regs_q[5];

	// second uart controls
	wire [2:0] ser_mode;
	assign ser_mode = regs_q[6][5:3];
	assign o_uart2_rx     = i_uart2_rx_pin ^ regs_q[6][0];
	assign o_uart2_tx_pin = i_uart2_tx ^ regs_q[6][1];
	assign o_uart2_half_duplex = regs_q[6][2];
	assign o_uart2_serial_infrared_mode     = (ser_mode == `MIOC_SER_SIR);
	assign o_uart2_amplitude_keyed_infrared = (ser_mode == `MIOC_SER_ASK);
	// reserved codes flagged so the uart can fall back to standard
	assign o_uart2_mode_reserved = (ser_mode != `MIOC_SER_STD)
		&& (ser_mode != `MIOC_SER_SIR) && (ser_mode != `MIOC_SER_ASK);
	assign o_uart1_high_speed = regs_q[6][6];
	assign o_uart2_high_speed = regs_q[6][7];

	// decoder: mid bits from 08h, top bits from 09h, low nibble matched per mode
	mioc_addr_dec u_dec (
		.i_match_bits              ({regs_q[3][2:0], regs_q[2][3:0]}),
		.i_mode                    (regs_q[3][7:6]),
		.i_addr                    (i_addr),
		.i_chip_select_qualifier_n (i_chip_select_qualifier_n),
		.o_hit                     (o_general_address_decoder_output)
	);
endmodule // mioc_cfg_regs
`default_nettype wire

// [multi_io_config_regs_06_0c_bench.sv]
`default_nettype none
module multi_io_config_regs_06_0c_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_cfg_mode = 1'b0, i_wr_stb = 1'b0, i_rd_stb = 1'b0;
	logic i_chip_select_qualifier_n = 1'b1, i_uart2_rx_pin = 1'b0, i_uart2_tx = 1'b0;
	logic [7:0] i_config_select_index = 8'h00, i_wr_data = 8'h00, rd;
	logic [10:0] i_addr = 11'h000;
	wire [7:0] o_rd_data, o_floppy_drive_types, o_rate_table_select_bit;
	wire [3:0] o_fifo_threshold_bit;
	wire [1:0] o_boot_drive;
	wire o_rd_hit, o_general_address_decoder_output, o_uart2_rx, o_uart2_tx_pin, o_apd_parallel,
		o_apd_uart2, o_apd_uart1, o_apd_floppy, o_uart2_half_duplex, o_uart2_serial_infrared_mode,
		o_uart2_amplitude_keyed_infrared, o_uart2_mode_reserved, o_uart1_high_speed,
		o_uart2_high_speed;
	int mismatches = 0, n_tests = 0;
	mioc_cfg_regs dut_u (.*);
	always #25 i_core_clk = ~i_core_clk;
	task chk(input string nm, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// one write; md picks config mode for this and later accesses
	task wr(input logic md, input logic [7:0] x, d);
		@(posedge i_core_clk);
		{i_cfg_mode, i_config_select_index, i_wr_data, i_wr_stb} <= {md, x, d, 1'b1};
		@(posedge i_core_clk);
		i_wr_stb <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task rdr(input logic [7:0] x);
		@(posedge i_core_clk);
		{i_config_select_index, i_rd_stb} <= {x, 1'b1};
		@(posedge i_core_clk);
		i_rd_stb <= 1'b0;
		#1 rd = o_rd_data;
	endtask
	task end_of_test;
		if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// reset values, then all ones written through the writable masks
	task t_regs;
		logic [7:0] m [7] = '{8'hff, 8'hf3, 8'h0f, 8'hc7, 8'h0f, 8'hff, 8'hff};
		for (int i = 0; i < 7; i++) begin
			rdr(8'(6 + i));
			chk("reset", (i == 0) ? 8'hff : 8'h00, rd);
			wr(1'b1, 8'(6 + i), 8'hff);
			rdr(8'(6 + i));
			chk("mask", m[i], rd);
		end
		chk("types", 8'hff, o_floppy_drive_types);
		chk("rates", 8'hff, o_rate_table_select_bit);
	endtask
	// closed mode and unmapped index leave the bank untouched
	task t_refuse;
		wr(1'b1, 8'h0b, 8'h5a);
		wr(1'b0, 8'h0b, 8'h00);
		rdr(8'h0b);
		chk("closed", 8'h00, rd);
		wr(1'b1, 8'h0d, 8'hff);
		rdr(8'h0d);
		chk("unmapped", 8'h00, rd);
		rdr(8'h0b);
		chk("kept", 8'h5a, rd);
	endtask
	// every mode code with polarity, duplex and speed bits
	task t_uart;
		for (int m = 0; m < 8; m++) begin
			wr(1'b1, 8'h0c, 8'(m * 8 + 8'hc5));
			{i_uart2_rx_pin, i_uart2_tx} <= 2'b10;
			#1 chk("serial", {m == 1, m == 2, m > 2, 5'h07}, {o_uart2_serial_infrared_mode,
				o_uart2_amplitude_keyed_infrared, o_uart2_mode_reserved, o_uart2_rx,
				o_uart2_tx_pin, o_uart2_half_duplex, o_uart1_high_speed, o_uart2_high_speed});
		end
		wr(1'b1, 8'h0c, 8'h02);
		#1 chk("polarity", 8'h03, {6'h00, o_uart2_rx, o_uart2_tx_pin});
	endtask
	// power-down and boot bits, then a reset in mid-run
	task t_apd;
		wr(1'b1, 8'h07, 8'ha1);
		#1 chk("apd", 8'ha1, {o_apd_floppy, o_apd_uart1, o_apd_uart2, o_apd_parallel,
			2'h0, o_boot_drive});
		@(posedge i_core_clk) i_rst <= 1'b1;
		@(posedge i_core_clk) i_rst <= 1'b0;
		#1 chk("apd reset", 8'h00, {o_apd_floppy, o_apd_uart1, o_apd_uart2, o_apd_parallel,
			2'h0, o_boot_drive});
		rdr(8'h0c);
		chk("mode reset", 8'h00, rd);
	endtask
	// decoder at base 350h: block edges, a miss, qualifier high
	task t_dec;
		logic [10:0] a [5] = '{11'h350, 11'h357, 11'h358, 11'h360, 11'h350};
		logic [4:0] e [4] = '{5'h00, 5'h10, 5'h18, 5'h1c};
		logic [4:0] h;
		wr(1'b1, 8'h08, 8'h05);
		for (int m = 0; m < 4; m++) begin
			wr(1'b1, 8'h09, 8'(m * 64 + 3));
			for (int k = 0; k < 5; k++) begin
				@(posedge i_core_clk);
				{i_chip_select_qualifier_n, i_addr} <= {k == 4, a[k]};
				#1 h[4 - k] = o_general_address_decoder_output;
			end
			chk("decode", {3'h0, e[m]}, {3'h0, h});
		end
	endtask
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		i_cfg_mode <= 1'b1;
		t_regs;
		t_refuse;
		t_uart;
		t_apd;
		t_dec;
		end_of_test;
	end
endmodule // multi_io_config_regs_06_0c_bench
`default_nettype wire
